// file: spio_map.vh
// Register map and reset values of the shared parallel I/O ports
// Behaviour
// - Twenty-six pins, each also usable by peripherals
// - Direction bit chooses input or output per pin
// - Output pins driven from output data latch, undriven while analog enabled
// - Input pins read back live pin level, zero while analog enabled
// - Analog enable registers reset to all ones
// - Port 8 shared: interrupts, edge capture, serial
// - Port 9 shared: I2C lines, serial channel three
// - Port A: analog inputs, lowest pin time clock
// - Port B: analog, serial two, interrupts, timer
`ifndef SPIO_MAP_VH
`define SPIO_MAP_VH
`define SPIO_OFF_DAT8 8'h08
`define SPIO_OFF_DAT9 8'h09
`define SPIO_OFF_DATA 8'h0a
`define SPIO_OFF_DATB 8'h0b
`define SPIO_OFF_DIR8 8'h18
`define SPIO_OFF_DIR9 8'h19
`define SPIO_OFF_DIRA 8'h1a
`define SPIO_OFF_DIRB 8'h1b
`define SPIO_OFF_ANA0 8'h1e
`define SPIO_OFF_ANA1 8'h1f
`define SPIO_OFF_SEL8 8'h40
`define SPIO_OFF_SEL9 8'h41
`define SPIO_OFF_SELA 8'h42
`define SPIO_OFF_SELB 8'h43
`define SPIO_RST_DIR 8'h00
`define SPIO_RST_DAT 8'h00
`define SPIO_RST_ANA 8'hff
`define SPIO_RST_SEL 8'h00
`endif

// file: spio_pin_slice.v
// One port bit: pin drive, readback and peripheral sharing
`timescale 1ns/1ps
module spio_pin_slice (
  input wire clk, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire dirOut, // 1 selects output
  input wire latchBit, // Output data latch bit
  input wire perSel, // 1 hands the output to the peripheral
  input wire perOut, // Peripheral output value
  input wire perOe, // Peripheral wants to drive
  input wire anaEn, // Analog input enabled on this pin
  input wire openDrain, // Pin is open drain
  input wire pinIn, // Level at the pin
  output reg pinOut_q, // Pin output value
  output reg pinOe_q, // Pin output enable
  output reg rdBit_q, // Value seen by a data register read
  output reg perIn_q // Pin level toward peripherals
);
  reg drvVal;
  reg drvEn;
  always @* begin
    drvVal = perSel ? perOut : latchBit;
    drvEn = perSel ? perOe : dirOut;
    if (anaEn) begin
      drvEn = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      pinOut_q <= 1'b0;
      pinOe_q <= 1'b0;
      rdBit_q <= 1'b0;
      perIn_q <= 1'b0;
    end else begin
      if (openDrain) begin
        pinOut_q <= 1'b0;
        pinOe_q <= drvEn & ~drvVal;
      end else begin
        pinOut_q <= drvVal;
        pinOe_q <= drvEn;
      end
      // Analog pins read as zero unless set as output, so a floating level never reaches logic
      rdBit_q <= dirOut ? latchBit : (pinIn & ~anaEn);
      perIn_q <= pinIn & ~anaEn;
    end
  end
endmodule // spio_pin_slice

// file: spio_ports.v
// Four shared I/O ports with a classic Wishbone register slave
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "spio_map.vh"
module spio_ports (
  input wire clk, // System clock, 50 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte select
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire [25:0] pinIn, // Pin levels: P8[7:0] P9[9:8] PA[17:10] PB[25:18]
  output wire [25:0] pinOut, // Pin output values
  output wire [25:0] pinOe, // Pin output enables, high while driving
  input wire [25:0] perOut, // Peripheral output values per pin
  input wire [25:0] perOe, // Peripheral output enables per pin
  output wire [25:0] perIn, // Pin levels toward peripherals
  output reg [15:0] analogEn // Analog input enables, PA then PB
);
  reg [7:0] dir8_q;
  reg [7:0] dir9_q;
  reg [7:0] dirA_q;
  reg [7:0] dirB_q;
  reg [7:0] dat8_q;
  reg [7:0] dat9_q;
  reg [7:0] datA_q;
  reg [7:0] datB_q;
  reg [7:0] ana0_q;
  reg [7:0] ana1_q;
  reg [7:0] sel8_q;
  reg [7:0] sel9_q;
  reg [7:0] selA_q;
  reg [7:0] selB_q;
  reg [7:0] dir8_d;
  reg [7:0] dir9_d;
  reg [7:0] dirA_d;
  reg [7:0] dirB_d;
  reg [7:0] dat8_d;
  reg [7:0] dat9_d;
  reg [7:0] datA_d;
  reg [7:0] datB_d;
  reg [7:0] ana0_d;
  reg [7:0] ana1_d;
  reg [7:0] sel8_d;
  reg [7:0] sel9_d;
  reg [7:0] selA_d;
  reg [7:0] selB_d;
  wire [25:0] dirAll;
  wire [25:0] latAll;
  wire [25:0] selAll;
  wire [25:0] anaAll;
  wire [25:0] rdAll;
  wire req;
  wire wrLane0;
  // One write enable per register byte
  wire wrDat8;
  wire wrDat9;
  wire wrDatA;
  wire wrDatB;
  wire wrDir8;
  wire wrDir9;
  wire wrDirA;
  wire wrDirB;
  wire wrAna0;
  wire wrAna1;
  wire wrSel8;
  wire wrSel9;
  wire wrSelA;
  wire wrSelB;
  reg [7:0] rdByte;

  function isOffset;
    input [7:0] adr;
    input [7:0] off;
    begin
      isOffset = (adr == off);
    end
  endfunction

  // Each port register is one byte at its own address, always in lane 0
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrLane0 = req & wb_we_i & wb_sel_i[0];
  // Exact decode: an aliased write would reconfigure every port at once
  assign wrDat8 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DAT8);
  assign wrDat9 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DAT9);
  assign wrDatA = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DATA);
  assign wrDatB = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DATB);
  assign wrDir8 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DIR8);
  assign wrDir9 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DIR9);
  assign wrDirA = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DIRA);
  assign wrDirB = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_DIRB);
  assign wrAna0 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_ANA0);
  assign wrAna1 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_ANA1);
  assign wrSel8 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_SEL8);
  assign wrSel9 = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_SEL9);
  assign wrSelA = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_SELA);
  assign wrSelB = wrLane0 & isOffset(wb_adr_i, `SPIO_OFF_SELB);

  // Pin map: port 8 from bit 0, port 9 from 8, port A from 10, port B from 18
  assign dirAll = {dirB_q, dirA_q, dir9_q[1:0], dir8_q};
  assign latAll = {datB_q, datA_q, dat9_q[1:0], dat8_q};
  assign selAll = {selB_q, selA_q, sel9_q[1:0], sel8_q};
  assign anaAll = {ana1_q, ana0_q, 10'h000};

  genvar i;
  generate
    for (i = 0; i < 26; i = i + 1) begin : gPin
      // Port 9 carries the I2C lines and serial channel three
      spio_pin_slice uSlice (
        .clk(clk),
        .sys_rst(sys_rst),
        .dirOut(dirAll[i]),
        .latchBit(latAll[i]),
        .perSel(selAll[i]),
        .perOut(perOut[i]),
        .perOe(perOe[i]),
        .anaEn(anaAll[i]),
        .openDrain((i == 8) || (i == 9)),
        .pinIn(pinIn[i]),
        .pinOut_q(pinOut[i]),
        .pinOe_q(pinOe[i]),
        .rdBit_q(rdAll[i]),
        .perIn_q(perIn[i])
      );
    end
  endgenerate

  // Unmapped addresses read as zero
  always @* begin
    rdByte = 8'h00;
    if (isOffset(wb_adr_i, `SPIO_OFF_DAT8)) rdByte = rdAll[7:0];
    if (isOffset(wb_adr_i, `SPIO_OFF_DAT9)) rdByte = {6'h00, rdAll[9:8]};
    if (isOffset(wb_adr_i, `SPIO_OFF_DATA)) rdByte = rdAll[17:10];
    if (isOffset(wb_adr_i, `SPIO_OFF_DATB)) rdByte = rdAll[25:18];
    if (isOffset(wb_adr_i, `SPIO_OFF_DIR8)) rdByte = dir8_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_DIR9)) rdByte = {6'h00, dir9_q[1:0]};
    if (isOffset(wb_adr_i, `SPIO_OFF_DIRA)) rdByte = dirA_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_DIRB)) rdByte = dirB_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_ANA0)) rdByte = ana0_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_ANA1)) rdByte = ana1_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_SEL8)) rdByte = sel8_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_SEL9)) rdByte = {6'h00, sel9_q[1:0]};
    if (isOffset(wb_adr_i, `SPIO_OFF_SELA)) rdByte = selA_q;
    if (isOffset(wb_adr_i, `SPIO_OFF_SELB)) rdByte = selB_q;
  end

  // Registers keep their value unless their own byte is written
  always @* begin
    dat8_d = dat8_q;
    dat9_d = dat9_q;
    datA_d = datA_q;
    datB_d = datB_q;
    dir8_d = dir8_q;
    dir9_d = dir9_q;
    dirA_d = dirA_q;
    dirB_d = dirB_q;
    ana0_d = ana0_q;
    ana1_d = ana1_q;
    sel8_d = sel8_q;
    sel9_d = sel9_q;
    selA_d = selA_q;
    selB_d = selB_q;
    if (wrDat8) dat8_d = wb_dat_i[7:0];
    if (wrDat9) dat9_d = {6'h00, wb_dat_i[1:0]};
    if (wrDatA) datA_d = wb_dat_i[7:0];
    if (wrDatB) datB_d = wb_dat_i[7:0];
    if (wrDir8) dir8_d = wb_dat_i[7:0];
    if (wrDir9) dir9_d = {6'h00, wb_dat_i[1:0]};
    if (wrDirA) dirA_d = wb_dat_i[7:0];
    if (wrDirB) dirB_d = wb_dat_i[7:0];
    // Digital use needs these cleared by software
    if (wrAna0) ana0_d = wb_dat_i[7:0];
    if (wrAna1) ana1_d = wb_dat_i[7:0];
    if (wrSel8) sel8_d = wb_dat_i[7:0];
    if (wrSel9) sel9_d = {6'h00, wb_dat_i[1:0]};
    if (wrSelA) selA_d = wb_dat_i[7:0];
    if (wrSelB) selB_d = wb_dat_i[7:0];
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      dir8_q <= `SPIO_RST_DIR;
      dir9_q <= `SPIO_RST_DIR;
      dirA_q <= `SPIO_RST_DIR;
      dirB_q <= `SPIO_RST_DIR;
      dat8_q <= `SPIO_RST_DAT;
      dat9_q <= `SPIO_RST_DAT;
      datA_q <= `SPIO_RST_DAT;
      datB_q <= `SPIO_RST_DAT;
      ana0_q <= `SPIO_RST_ANA;
      ana1_q <= `SPIO_RST_ANA;
      sel8_q <= `SPIO_RST_SEL;
      sel9_q <= `SPIO_RST_SEL;
      selA_q <= `SPIO_RST_SEL;
      selB_q <= `SPIO_RST_SEL;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      analogEn <= {`SPIO_RST_ANA, `SPIO_RST_ANA};
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h000000, rdByte} : 32'h00000000;
      // Converter copy lags the registers by one clock, like the pins
      analogEn <= {ana1_q, ana0_q};
      dat8_q <= dat8_d;
      dat9_q <= dat9_d;
      datA_q <= datA_d;
      datB_q <= datB_d;
      dir8_q <= dir8_d;
      dir9_q <= dir9_d;
      dirA_q <= dirA_d;
      dirB_q <= dirB_d;
      ana0_q <= ana0_d;
      ana1_q <= ana1_d;
      sel8_q <= sel8_d;
      sel9_q <= sel9_d;
      selA_q <= selA_d;
      selB_q <= selB_d;
    end
  end
endmodule // spio_ports

// file: spio_ports_props.sv
// Checker for the shared I/O port block
`timescale 1ns/1ps
module spio_ports_props (
  input wire clk, // Clock
  input wire sys_rst, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Ack
  input wire [25:0] pinOut, // Pin values
  input wire [25:0] pinOe, // Pin enables
  input wire [25:0] perIn, // To peripherals
  input wire [15:0] analogEn // Analog enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Two cycles at all ones, so a register that was just rewritten is not judged early
  sequence anaHeld;
    analogEn[7:0] == 8'hff && $past(analogEn[7:0]) == 8'hff;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("late ack");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  ana_rst_a: assert property ($past(sys_rst) |-> analogEn == 16'hffff)
    else $error("analog reset");
  drv_rst_a: assert property ($past(sys_rst) |-> pinOe == 26'h0) else $error("drive");
  od_low_a: assert property (pinOut[9:8] == 2'h0) else $error("port 9 high");
  ana_quiet_a: assert property (anaHeld |-> pinOe[17:10] == 8'h0) else $error("driven");
  ana_perin_a: assert property (anaHeld |-> perIn[17:10] == 8'h0) else $error("seen");
  pa_cause_a: assert property (!$stable(pinOe[17:10]) |-> $past(wb_ack_o && wb_we_i))
    else $error("port A moved");
  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && !wb_we_i);
  cover property (pinOe[8]);
endmodule // spio_ports_props
bind spio_ports spio_ports_props u_props (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pinOut(pinOut), .pinOe(pinOe), .perIn(perIn), .analogEn(analogEn));

// file: spio_pin_world.sv
// Circuits outside the pins
`timescale 1ns/1ps
module spio_pin_world (
  input wire [25:0] pinOut, // Device pin values
  input wire [25:0] pinOe, // Device drive enables
  input wire [25:0] extVal, // Outside drive, port 9 pull-up included
  output wire [25:0] pinLvl // Resolved levels
);
  assign pinLvl = (pinOe & pinOut) | (~pinOe & extVal);
endmodule // spio_pin_world

// file: tb.sv
// Self-checking bench for the shared I/O ports
`timescale 1ns/1ps
module tb;
  logic clk, sys_rst, cyc, stb, we, ack;
  logic [7:0] adr, d, v, m;
  logic [31:0] wdat, rdat, x;
  logic [25:0] pinIn, pinOut, pinOe, perOut, perOe, perIn, extVal;
  logic [15:0] analogEn;
  logic [31:0] expQ[$];
  int mismatches = 0, checked = 0, b;
  spio_ports u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .perOut(perOut),
    .perOe(perOe), .perIn(perIn), .analogEn(analogEn));
  spio_pin_world u_world (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .pinLvl(pinIn));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task give_verdict;
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Reads note their expectation; write data lane doubles as the note
  task wb(input logic w, input logic [7:0] a, input logic [31:0] dd);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, dd};
    if (!w) expQ.push_back(dd);
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  always @(posedge clk) if (ack && !we) chk(rdat, expQ.pop_front());
  initial begin
    #100us;
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hc60a));
    {cyc, stb, we, adr, wdat, extVal} <= '0;
    perOut <= 26'($urandom);
    perOe <= 26'($urandom);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    wb(0, 8'h1e, 32'hff);
    wb(0, 8'h1f, 32'hff);
    wb(0, 8'h0c, 32'h0);
    wb(1, 8'h1e, 32'h0);
    wb(1, 8'h1f, 32'h0);
    for (int p = 0; p < 4; p++) begin
      b = p == 0 ? 0 : p == 1 ? 8 : p * 8 - 6;
      m = p == 1 ? 8'h03 : 8'hff;
      d = 8'($urandom) & m;
      v = 8'($urandom) & m;
      x = $urandom;
      extVal <= x[25:0];
      wb(1, 8'h18 + p, d);
      wb(1, 8'h08 + p, v);
      repeat (2) @(posedge clk);
      chk(pinOe[b +: 8] & m, p == 1 ? d & ~v : d);
      if (p != 1) chk(pinOut[b +: 8] & d, v & d);
      chk(perIn[b +: 8] & m, p == 1 ? x[b +: 8] & ~(d & ~v) & m
        : (v & d) | (x[b +: 8] & ~d & m));
      wb(0, 8'h08 + p, (v & d) | (x[b +: 8] & ~d & m));
    end
    wb(1, 8'h40, 32'hff);
    repeat (3) @(posedge clk);
    chk(pinOe[7:0], perOe[7:0]);
    chk(pinOut[7:0] & perOe[7:0], perOut[7:0] & perOe[7:0]);
    d = 8'($urandom);
    v = 8'($urandom);
    wb(1, 8'h1a, d);
    wb(1, 8'h0a, v);
    wb(1, 8'h1e, 32'hff);
    repeat (2) @(posedge clk);
    chk(pinOe[17:10], 32'h0);
    chk(perIn[17:10], 32'h0);
    chk(analogEn, 32'h00ff);
    wb(0, 8'h0a, v & d);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(pinOe, 32'h0);
    wb(0, 8'h1e, 32'hff);
    wb(0, 8'h1f, 32'hff);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule // tb
